// File: pkg/jbl2d_pkg.sv
package jbl2d_pkg;

	// =========================================================
	// Instruction opcodes
	localparam logic [7:0] OP_EXTEST        = 8'h00;
	localparam logic [7:0] OP_SAMPLE        = 8'h81;
	localparam logic [7:0] OP_BYPASS        = 8'hFF;
	localparam logic [7:0] OP_IDCODE        = 8'hAA;
	localparam logic [7:0] OP_UNPARK        = 8'hE7;
	localparam logic [7:0] OP_PARK_RESET    = 8'hC5;
	localparam logic [7:0] OP_PARK_IDLE     = 8'h84;
	localparam logic [7:0] OP_PARK_PAUSE    = 8'hC6;
	localparam logic [7:0] OP_RETURN_WAIT   = 8'hC3;
	localparam logic [7:0] OP_SOFT_RESET    = 8'h88;
	localparam logic [7:0] OP_CFG0          = 8'h8E;
	localparam logic [7:0] OP_CFG1          = 8'h82;
	localparam logic [7:0] OP_CFG2          = 8'h83;
	localparam logic [7:0] OP_CFG3          = 8'h85;
	localparam logic [7:0] OP_GROUP         = 8'h03;
	localparam logic [7:0] OP_SIG_SEL       = 8'hC9;
	localparam logic [7:0] OP_SIG_START     = 8'h0C;
	localparam logic [7:0] OP_SIG_STOP      = 8'h8D;
	localparam logic [7:0] OP_CNT_SEL       = 8'hCE;
	localparam logic [7:0] OP_CNT_START     = 8'h0F;
	localparam logic [7:0] OP_CNT_STOP      = 8'h90;
	localparam logic [7:0] OP_DEF_BYPASS    = 8'h07;
	localparam logic [4:0] OP_PASS_PREFIX   = 5'h14;   // A0..A7
	localparam logic [4:0] OP_DIO_PREFIX    = 5'h16;   // B0..B7
	localparam logic [4:0] OP_SIO_PREFIX    = 5'h17;   // B8..BF

	// =========================================================
	// Reset values and widths
	localparam int          IR_WIDTH        = 8;
	localparam logic [7:0]  IR_RESET        = 8'hAA;
	localparam int          NUM_PORTS       = 3;
	localparam int          SYNC_STAGES     = 3;

	// =========================================================
	// Types
	typedef enum logic [3:0] {
		JBL2D_DR_BYPASS, JBL2D_DR_BOUNDARY, JBL2D_DR_IDCODE, JBL2D_DR_CFG,
		JBL2D_DR_GROUP, JBL2D_DR_SIGNATURE, JBL2D_DR_COUNTER,
		JBL2D_DR_PASS, JBL2D_DR_DIO, JBL2D_DR_SIO, JBL2D_DR_PORTS
	} jbl2d_dr_type;

	typedef enum logic [1:0] {
		JBL2D_SEL_WAIT, JBL2D_SEL_DIRECT, JBL2D_SEL_GROUP, JBL2D_SEL_NONE
	} jbl2d_sel_type;

	typedef enum logic [1:0] {
		JBL2D_PARK_RESET, JBL2D_PARK_IDLE, JBL2D_PARK_PAUSE
	} jbl2d_park_type;

	// Selection input from the address matcher
	typedef struct packed {
		logic          match;       // Pulse: address update resolved
		logic          multi;       // Match came via broadcast or group address
		logic          miss;        // Pulse: address update did not match
	} jbl2d_addr_type;

	// Decoded data register choice
	typedef struct packed {
		jbl2d_dr_type  reg_kind;
		logic [2:0]    reg_index;
	} jbl2d_chain_type;

	// One-cycle command strobes
	typedef struct packed {
		logic          unpark;
		logic          park_valid;
		jbl2d_park_type park_kind;
		logic          soft_reset;
		logic          sig_start;
		logic          sig_stop;
		logic          cnt_start;
		logic          cnt_stop;
	} jbl2d_cmd_type;

endpackage

// File: verilog/jbl2d_decoder.sv
`timescale 1ns/1ns
// Summary of operation
// - Accept instructions only after address selection
// - Float data out under group selection
// - Local ports stay parked until unparked
// - Before selection chain holds only IR/ID
// - E7 inserts configured local ports
// - Select instructions route chosen register
// - FF bypass, 00/81 boundary, AA ID
// - 8E,82,83,85 configs; 03 group register
// - Control and undefined opcodes select ID
// - C5,84,C6 park; C3 wait; 88 reset
// - C9 signature; 0C start, 8D stop
// - CE counter; 0F start, 90 stop
// - C3 works unselected; others need selection
// - 07 makes bypass the default register
module jbl2d_decoder #(
	parameter bit EXTENDED = 1'b1
) (
	input  wire logic                     MCLK,
	input  wire logic                     NRST,
	input  wire logic                     TCK,
	input  wire logic                     TEST_RESET,
	input  wire logic                     CAPTURE_IR,
	input  wire logic                     SHIFT_IR,
	input  wire logic                     UPDATE_IR,
	input  wire logic                     SHIFT_DR,
	input  wire logic                     BACKPLANE_DATA_IN,
	input  wire logic                     CHAIN_DATA_OUT,
	input  wire jbl2d_pkg::jbl2d_addr_type ADDR,
	output logic                          BACKPLANE_DATA_OUT,
	output logic                          BACKPLANE_DATA_OUT_OE_N,
	output jbl2d_pkg::jbl2d_chain_type     CHAIN,
	output jbl2d_pkg::jbl2d_cmd_type       CMD,
	output logic                          SELECTED,
	output logic                          PORTS_IN_CHAIN,
	output logic [7:0]                    IR_VALUE
);
	import jbl2d_pkg::*;

	// =========================================================
	// Elaboration checks
	// The slices below assume an eight-bit opcode and a three-stage synchroniser
	if (IR_WIDTH != 8 || SYNC_STAGES != 3) begin : g_bad_size
		$error("instruction width must be 8 and sync depth 3");
	end

	// =========================================================
	// Pin synchronisers; stage 0 feeds only stage 1
	logic [SYNC_STAGES-1:0] tck_sync_reg;
	logic [SYNC_STAGES-1:0] tdi_sync_reg;
	logic                   tck_level_reg;
	logic                   tdi_level_reg;
	logic                   tck_rise;
	logic                   tck_fall;

	// Three stages; a change counts when the last two agree
	always_ff @(posedge MCLK) begin
		if (!NRST) begin
			tck_sync_reg <= '0;
			tdi_sync_reg <= '0;
		end else begin
			tck_sync_reg <= {tck_sync_reg[SYNC_STAGES-2:0], TCK};
			tdi_sync_reg <= {tdi_sync_reg[SYNC_STAGES-2:0], BACKPLANE_DATA_IN};
		end
	end

	// Filtered levels, updated only when stages 1 and 2 agree
	always_ff @(posedge MCLK) begin
		if (!NRST) begin
			tck_level_reg <= 1'b0;
			tdi_level_reg <= 1'b0;
		end else begin
			if (tck_sync_reg[1] == tck_sync_reg[2]) begin
				tck_level_reg <= tck_sync_reg[2];
			end
			if (tdi_sync_reg[1] == tdi_sync_reg[2]) begin
				tdi_level_reg <= tdi_sync_reg[2];
			end
		end
	end

	assign tck_rise = (tck_sync_reg[1] == tck_sync_reg[2]) && tck_sync_reg[2] && !tck_level_reg;
	assign tck_fall = (tck_sync_reg[1] == tck_sync_reg[2]) && !tck_sync_reg[2] && tck_level_reg;

	// =========================================================
	// Instruction shift and update registers
	logic [7:0]     shift_reg;
	logic [7:0]     ir_reg;
	logic [7:0]     ir_next;
	logic           update_pulse;
	jbl2d_sel_type  sel_reg;
	logic           def_bypass_reg;
	logic           ports_reg;
	logic           tdo_reg;
	logic           oe_n_reg;

	assign update_pulse = tck_rise && UPDATE_IR;

	// Opcode enters LSB first: new bit goes in at the top
	always_ff @(posedge MCLK) begin
		if (!NRST) begin
			shift_reg <= IR_RESET;
		end else if (tck_rise && CAPTURE_IR) begin
			shift_reg <= 8'h01; // Fixed capture pattern
		end else if (tck_rise && SHIFT_IR) begin
			shift_reg <= {tdi_level_reg, shift_reg[7:1]};
		end
	end

	// Instructions land only in a selected device; unselected, return-to-wait loads the reset opcode
	always_comb begin
		ir_next = ir_reg;
		if (TEST_RESET) begin
			ir_next = IR_RESET;
		end else if (update_pulse) begin
			if (sel_reg == JBL2D_SEL_DIRECT || sel_reg == JBL2D_SEL_GROUP) begin
				ir_next = shift_reg;
			end else if (shift_reg == OP_RETURN_WAIT) begin
				ir_next = IR_RESET;
			end
		end
	end

	always_ff @(posedge MCLK) begin
		if (!NRST) begin
			ir_reg <= IR_RESET;
		end else begin
			ir_reg <= ir_next;
		end
	end

	// =========================================================
	// Selection state, driven by the address matcher
	always_ff @(posedge MCLK) begin
		if (!NRST) begin
			sel_reg <= JBL2D_SEL_WAIT;
		end else if (TEST_RESET) begin
			sel_reg <= JBL2D_SEL_WAIT;
		end else if (update_pulse && shift_reg == OP_RETURN_WAIT) begin
			sel_reg <= JBL2D_SEL_WAIT;
		end else begin
			case (sel_reg)
				JBL2D_SEL_WAIT: begin
					if (ADDR.match) begin
						sel_reg <= ADDR.multi ? JBL2D_SEL_GROUP : JBL2D_SEL_DIRECT;
					end else if (ADDR.miss) begin
						sel_reg <= JBL2D_SEL_NONE;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Default register choice; persists until test reset
	always_ff @(posedge MCLK) begin
		if (!NRST) begin
			def_bypass_reg <= 1'b0;
		end else if (TEST_RESET) begin
			def_bypass_reg <= 1'b0;
		end else if (EXTENDED && update_pulse && ir_next == OP_DEF_BYPASS
				&& sel_reg != JBL2D_SEL_WAIT && sel_reg != JBL2D_SEL_NONE) begin
			def_bypass_reg <= 1'b1;
		end
	end

	// Ports join the chain only by unpark; parks and deselection drop them
	always_ff @(posedge MCLK) begin
		if (!NRST) begin
			ports_reg <= 1'b0;
		end else if (TEST_RESET || sel_reg == JBL2D_SEL_WAIT || sel_reg == JBL2D_SEL_NONE) begin
			ports_reg <= 1'b0;
		end else if (update_pulse) begin
			case (ir_next)
				OP_UNPARK:                    ports_reg <= 1'b1;
				OP_PARK_RESET, OP_PARK_IDLE,
				OP_PARK_PAUSE, OP_SOFT_RESET,
				OP_RETURN_WAIT:               ports_reg <= 1'b0;
				default:                      ports_reg <= ports_reg;
			endcase
		end
	end

	// =========================================================
	// Data register decode
	jbl2d_chain_type chain_next;

	always_comb begin
		// Index only means something for numbered register banks; zero elsewhere
		chain_next.reg_index = 3'h0;
		chain_next.reg_kind  = def_bypass_reg ? JBL2D_DR_BYPASS : JBL2D_DR_IDCODE;
		case (ir_reg)
			OP_BYPASS:            chain_next.reg_kind = JBL2D_DR_BYPASS;
			OP_EXTEST, OP_SAMPLE: chain_next.reg_kind = JBL2D_DR_BOUNDARY;
			OP_IDCODE:            chain_next.reg_kind = JBL2D_DR_IDCODE;
			OP_CFG0: begin
				chain_next.reg_kind  = JBL2D_DR_CFG;
				chain_next.reg_index = 3'h0;
			end
			OP_CFG1: begin
				chain_next.reg_kind  = JBL2D_DR_CFG;
				chain_next.reg_index = 3'h1;
			end
			OP_CFG2: begin
				chain_next.reg_kind  = JBL2D_DR_CFG;
				chain_next.reg_index = 3'h2;
			end
			OP_CFG3: begin
				chain_next.reg_kind  = JBL2D_DR_CFG;
				chain_next.reg_index = 3'h3;
			end
			OP_GROUP:             chain_next.reg_kind = JBL2D_DR_GROUP;
			OP_SIG_SEL:           chain_next.reg_kind = JBL2D_DR_SIGNATURE;
			OP_CNT_SEL:           chain_next.reg_kind = JBL2D_DR_COUNTER;
			default: begin
				if (ir_reg[7:3] == OP_PASS_PREFIX) begin
					chain_next.reg_kind  = JBL2D_DR_PASS;
					chain_next.reg_index = ir_reg[2:0];
				end else if (ir_reg[7:3] == OP_DIO_PREFIX) begin
					chain_next.reg_kind  = JBL2D_DR_DIO;
					chain_next.reg_index = ir_reg[2:0];
				end else if (ir_reg[7:3] == OP_SIO_PREFIX) begin
					chain_next.reg_kind  = JBL2D_DR_SIO;
					chain_next.reg_index = ir_reg[2:0];
				end
			end
		endcase
		// With E7 in the IR, unparked ports replace the chosen register during data scans
		if (ir_reg == OP_UNPARK && ports_reg) begin
			chain_next.reg_kind = JBL2D_DR_PORTS;
		end
	end

	// Registered so data outputs never glitch mid-scan
	always_ff @(posedge MCLK) begin
		if (!NRST) begin
			CHAIN <= '{reg_kind: JBL2D_DR_IDCODE, reg_index: 3'h0};
		end else begin
			CHAIN <= chain_next;
		end
	end

	// =========================================================
	// One-cycle command strobes on an accepted update
	always_ff @(posedge MCLK) begin
		if (!NRST) begin
			CMD <= '0;
		end else begin
			CMD <= '0;
			if (update_pulse && ir_next == shift_reg && sel_reg != JBL2D_SEL_WAIT
					&& sel_reg != JBL2D_SEL_NONE) begin
				CMD.unpark     <= (shift_reg == OP_UNPARK);
				CMD.soft_reset <= (shift_reg == OP_SOFT_RESET);
				CMD.sig_start  <= (shift_reg == OP_SIG_START);
				CMD.sig_stop   <= (shift_reg == OP_SIG_STOP);
				CMD.cnt_start  <= (shift_reg == OP_CNT_START);
				CMD.cnt_stop   <= (shift_reg == OP_CNT_STOP);
				case (shift_reg)
					OP_PARK_RESET, OP_RETURN_WAIT: begin
						CMD.park_valid <= 1'b1;
						CMD.park_kind  <= JBL2D_PARK_RESET;
					end
					OP_PARK_IDLE: begin
						CMD.park_valid <= 1'b1;
						CMD.park_kind  <= JBL2D_PARK_IDLE;
					end
					OP_PARK_PAUSE: begin
						CMD.park_valid <= 1'b1;
						CMD.park_kind  <= JBL2D_PARK_PAUSE;
					end
					default: begin
					end
				endcase
			end
		end
	end

	// =========================================================
	// Backplane data out: changes on the falling test clock
	always_ff @(posedge MCLK) begin
		if (!NRST) begin
			tdo_reg  <= 1'b0;
			oe_n_reg <= 1'b1;
		end else if (tck_fall) begin
			tdo_reg  <= SHIFT_IR ? shift_reg[0] : CHAIN_DATA_OUT;
			// Group-selected boards all listen; none may drive
			oe_n_reg <= !((SHIFT_IR || SHIFT_DR) && sel_reg == JBL2D_SEL_DIRECT);
		end
	end

	assign BACKPLANE_DATA_OUT      = tdo_reg;
	assign BACKPLANE_DATA_OUT_OE_N = oe_n_reg;
	assign SELECTED                = (sel_reg == JBL2D_SEL_DIRECT) || (sel_reg == JBL2D_SEL_GROUP);
	assign PORTS_IN_CHAIN          = ports_reg;
	assign IR_VALUE                = ir_reg;

endmodule

// File: verification/jbl2d_assertions.sv
`timescale 1ns/1ns
// ====
// Decoder port checker
module jbl2d_checker (
	input	wire logic				MCLK,
	input	wire logic				NRST,
	input	wire logic				TEST_RESET,
	input	wire jbl2d_pkg::jbl2d_addr_type		ADDR,
	input	wire logic				BACKPLANE_DATA_OUT_OE_N,
	input	wire jbl2d_pkg::jbl2d_chain_type	CHAIN,
	input	wire jbl2d_pkg::jbl2d_cmd_type		CMD,
	input	wire logic				SELECTED,
	input	wire logic				PORTS_IN_CHAIN,
	input	wire logic [7:0]			IR_VALUE
);
	import jbl2d_pkg::*;
	logic	multi_reg;
	logic	strobe;
	// Any command strobe; park_kind alone is not a strobe
	assign strobe = CMD.unpark | CMD.park_valid | CMD.soft_reset | CMD.sig_start
		| CMD.sig_stop | CMD.cnt_start | CMD.cnt_stop;
	// Remember whether the last match was a group match
	always_ff @(posedge MCLK) begin
		if (!NRST) begin
			multi_reg <= 1'b0;
		end else if (ADDR.match) begin
			multi_reg <= ADDR.multi;
		end
	end
	default clocking @(posedge MCLK); endclocking
	default disable iff (!NRST);
	sequence s_sel_rise;
		!SELECTED ##1 SELECTED;
	endsequence
	property p_sel_match; s_sel_rise |-> $past(ADDR.match); endproperty
	property p_group_float; SELECTED && multi_reg |-> BACKPLANE_DATA_OUT_OE_N; endproperty
	property p_drive_direct; !BACKPLANE_DATA_OUT_OE_N |-> SELECTED && !multi_reg; endproperty
	property p_cmd_pulse; strobe |=> !strobe; endproperty
	property p_unpark;
		CMD.unpark |-> ##[0:1] (CHAIN.reg_kind == JBL2D_DR_PORTS && PORTS_IN_CHAIN);
	endproperty
	property p_leave;
		$fell(SELECTED) |-> $past(TEST_RESET) || $past(ADDR.miss) || IR_VALUE == OP_RETURN_WAIT;
	endproperty
	property p_tap_reset; TEST_RESET |=> IR_VALUE == IR_RESET && !SELECTED; endproperty
	property p_sig_start; CMD.sig_start |-> IR_VALUE == OP_SIG_START; endproperty
	property p_cnt_start; CMD.cnt_start |-> IR_VALUE == OP_CNT_START; endproperty
	a_sel_match: assert property (p_sel_match) else $error("select without match");
	a_group_float: assert property (p_group_float) else $error("group drives out");
	a_drive_direct: assert property (p_drive_direct) else $error("stray drive");
	a_cmd_pulse: assert property (p_cmd_pulse) else $error("strobe too long");
	a_unpark: assert property (p_unpark) else $error("unpark without ports");
	a_leave: assert property (p_leave) else $error("deselect without cause");
	a_tap_reset: assert property (p_tap_reset) else $error("tap reset ignored");
	a_sig_start: assert property (p_sig_start) else $error("bad sig start");
	a_cnt_start: assert property (p_cnt_start) else $error("bad cnt start");
endmodule
bind jbl2d_decoder jbl2d_checker i_jbl2d_checker (.MCLK(MCLK), .NRST(NRST),
	.TEST_RESET(TEST_RESET), .ADDR(ADDR), .BACKPLANE_DATA_OUT_OE_N(BACKPLANE_DATA_OUT_OE_N),
	.CHAIN(CHAIN), .CMD(CMD), .SELECTED(SELECTED), .PORTS_IN_CHAIN(PORTS_IN_CHAIN),
	.IR_VALUE(IR_VALUE));

// File: verification/jbl2d_master.sv
`timescale 1ns/1ns
// ====
// Backplane test master; its clock stands still between frames
module jbl2d_master (
	input	wire logic	mclk,
	output	logic		tck,
	output	logic		test_reset,
	output	logic		cap_ir,
	output	logic		sh_ir,
	output	logic		up_ir,
	output	logic		sh_dr,
	output	logic		din
);
	initial {tck, test_reset, cap_ir, sh_ir, up_ir, sh_dr, din} = '0;
	// One 164 ns period; levels move only while the clock is low
	task cyc(input logic [4:0] lv);
		@(posedge mclk);
		{cap_ir, sh_ir, up_ir, sh_dr, din} <= lv;
		repeat (20) @(posedge mclk);
		tck <= 1'b1;
		repeat (20) @(posedge mclk);
		tck <= 1'b0;
	endtask
	// Unused data bits toggle, so no stale level passes for data
	task send_ir(input logic [7:0] op);
		cyc({4'b1000, ~din});
		for (int i = 0; i < 8; i++) cyc({4'b0100, op[i]});
		cyc({4'b0010, ~op[7]});
		cyc({4'b0000, op[7]});
	endtask
	// Short Test-Logic-Reset visit
	task reset_tap();
		@(posedge mclk);
		test_reset <= 1'b1;
		repeat (4) @(posedge mclk);
		test_reset <= 1'b0;
	endtask
endmodule

// File: verification/tb.sv
`timescale 1ns/1ns
module tb;
	import jbl2d_pkg::*;
	logic			mclk, nrst, chain_out, tck, trst, cap, shi, upd, shd, din, dout, oe_n, sel, pic, clr;
	logic [7:0]		ir;
	logic [8:0]		seen;
	jbl2d_addr_type		addr;
	jbl2d_chain_type	chain;
	jbl2d_cmd_type		cmd;
	int			err_total, num_checks;
	logic [7:0]		ctl_op [9] = '{OP_PARK_RESET, OP_PARK_IDLE, OP_PARK_PAUSE, OP_SOFT_RESET,
		OP_SIG_START, OP_SIG_STOP, OP_CNT_START, OP_CNT_STOP, 8'h55};
	logic [8:0]		ctl_cmd [9] = '{9'h080, 9'h0A0, 9'h0C0, 9'h010, 9'h008, 9'h004, 9'h002,
		9'h001, 9'h000};
	jbl2d_decoder #(.EXTENDED(1'b1)) i_jbl2d_decoder (.MCLK(mclk), .NRST(nrst), .TCK(tck),
		.TEST_RESET(trst), .CAPTURE_IR(cap), .SHIFT_IR(shi), .UPDATE_IR(upd), .SHIFT_DR(shd),
		.BACKPLANE_DATA_IN(din), .CHAIN_DATA_OUT(chain_out), .ADDR(addr),
		.BACKPLANE_DATA_OUT(dout), .BACKPLANE_DATA_OUT_OE_N(oe_n), .CHAIN(chain), .CMD(cmd),
		.SELECTED(sel), .PORTS_IN_CHAIN(pic), .IR_VALUE(ir));
	jbl2d_master i_jbl2d_master (.mclk(mclk), .tck(tck), .test_reset(trst), .cap_ir(cap),
		.sh_ir(shi), .up_ir(upd), .sh_dr(shd), .din(din));
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	// Collect strobes; park kind only counts with its valid bit
	always @(posedge mclk) begin
		seen <= clr ? 9'h0 : seen | (cmd & {2'b11, {2{cmd.park_valid}}, 5'h1F});
	end
	task wrap_up;
		if (err_total == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task chk(input logic [8:0] got, input logic [8:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Shift one opcode, then judge chain choice and strobes
	task op(input logic [7:0] o, input logic [6:0] ch, input logic [8:0] c);
		clr <= 1'b1;
		@(posedge mclk);
		clr <= 1'b0;
		i_jbl2d_master.send_ir(o);
		chk(9'(chain), 9'(ch));
		chk(seen, c);
	endtask
	task pick(input logic m);
		@(posedge mclk);
		addr <= {1'b1, m, 1'b0};
		@(posedge mclk);
		addr <= {1'b0, m, 1'b0};
		repeat (2) @(posedge mclk);
	endtask
	task t_start;
		chk(9'({chain, sel, oe_n}), 9'({JBL2D_DR_IDCODE, 3'h0, 2'h1}));
		chk(9'(ir), 9'(IR_RESET));
		op(OP_BYPASS, {JBL2D_DR_IDCODE, 3'h0}, 9'h0);
		pick(1'b0);
		chk(9'({sel, pic}), 9'h2);
	endtask
	task t_decode;
		op(OP_BYPASS, {JBL2D_DR_BYPASS, 3'h0}, 9'h0);
		op(OP_EXTEST, {JBL2D_DR_BOUNDARY, 3'h0}, 9'h0);
		op(OP_SAMPLE, {JBL2D_DR_BOUNDARY, 3'h0}, 9'h0);
		op(OP_IDCODE, {JBL2D_DR_IDCODE, 3'h0}, 9'h0);
		op(OP_CFG0, {JBL2D_DR_CFG, 3'h0}, 9'h0);
		op(OP_CFG1, {JBL2D_DR_CFG, 3'h1}, 9'h0);
		op(OP_CFG2, {JBL2D_DR_CFG, 3'h2}, 9'h0);
		op(OP_CFG3, {JBL2D_DR_CFG, 3'h3}, 9'h0);
		op(OP_GROUP, {JBL2D_DR_GROUP, 3'h0}, 9'h0);
		op(OP_SIG_SEL, {JBL2D_DR_SIGNATURE, 3'h0}, 9'h0);
		op(OP_CNT_SEL, {JBL2D_DR_COUNTER, 3'h0}, 9'h0);
		for (int i = 0; i < 8; i++) begin
			op({OP_PASS_PREFIX, i[2:0]}, {JBL2D_DR_PASS, i[2:0]}, 9'h0);
			op({OP_DIO_PREFIX, i[2:0]}, {JBL2D_DR_DIO, i[2:0]}, 9'h0);
			op({OP_SIO_PREFIX, i[2:0]}, {JBL2D_DR_SIO, i[2:0]}, 9'h0);
		end
		for (int i = 0; i < 9; i++) op(ctl_op[i], {JBL2D_DR_IDCODE, 3'h0}, ctl_cmd[i]);
		op(OP_UNPARK, {JBL2D_DR_PORTS, 3'h0}, 9'h100);
		chk(9'(pic), 9'h1);
	endtask
	// Data scan: direct selection drives, group selection floats
	task t_scan(input logic [1:0] exp);
		chain_out <= 1'b1;
		i_jbl2d_master.cyc(5'b00010);
		repeat (8) @(posedge mclk);
		chk(9'({oe_n, exp[0] ? dout : 1'b0}), 9'(exp));
		i_jbl2d_master.cyc(5'b00000);
	endtask
	task t_leave;
		op(OP_RETURN_WAIT, {JBL2D_DR_IDCODE, 3'h0}, 9'h080);
		chk(9'(sel), 9'h0);
		@(posedge mclk);
		addr <= 3'b001;
		@(posedge mclk);
		addr <= 3'b000;
		op(OP_BYPASS, {JBL2D_DR_IDCODE, 3'h0}, 9'h0);
		op(OP_RETURN_WAIT, {JBL2D_DR_IDCODE, 3'h0}, 9'h0);
		pick(1'b1);
		chk(9'(sel), 9'h1);
	endtask
	task t_default;
		op(OP_DEF_BYPASS, {JBL2D_DR_BYPASS, 3'h0}, 9'h0);
		op(8'h55, {JBL2D_DR_BYPASS, 3'h0}, 9'h0);
		i_jbl2d_master.reset_tap();
		repeat (2) @(posedge mclk);
		chk({sel, ir}, {1'b0, IR_RESET});
		pick(1'b0);
		op(8'h55, {JBL2D_DR_IDCODE, 3'h0}, 9'h0);
	endtask
	initial begin
		{nrst, chain_out, addr, clr} = '0;
		repeat (5) @(posedge mclk);
		nrst <= 1'b1;
		repeat (4) @(posedge mclk);
		t_start;
		t_decode;
		t_scan(2'b01);
		t_leave;
		t_scan(2'b10);
		t_default;
		wrap_up;
	end
	// Watchdog well beyond the expected run
	initial begin
		#150000;
		err_total++;
		wrap_up;
	end
endmodule
